//--- core/mse_pkg.sv
package mse_pkg;

    // ------------------------------------------------------------
    // Command codes, counts and addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  MSE_RUN_CMD    = 8'h28;
    localparam logic [7:0]  MSE_RDSP_CMD   = 8'h0C;
    localparam int          MSE_SEC_BYTES  = 8;
    localparam logic [7:0]  MSE_ERASED     = 8'hFF;
    localparam logic [7:0]  MSE_FLAG_ADDR  = 8'h80;
    localparam int          MSE_FLAG_BIT   = 6;
    localparam logic [15:0] MSE_SP_INC     = 16'h0001;
    localparam logic [15:0] MSE_PC_HI_OFS  = 16'h0005;
    localparam logic [15:0] MSE_PC_LO_OFS  = 16'h0006;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        software_interrupt_op    = 2'b00,
        push_index_high_op       = 2'b01,
        pop_index_high_op        = 2'b10,
        return_from_interrupt_op = 2'b11
    } mse_op_t;

    typedef enum logic [3:0] {
        ST_SWI   = 4'b0000,
        ST_SWI_W = 4'b0001,
        ST_PSH   = 4'b0010,
        ST_PSH_W = 4'b0011,
        ST_SEC   = 4'b0100,
        ST_FLAG  = 4'b0101,
        ST_BRK   = 4'b0110,
        ST_CMD   = 4'b0111,
        ST_PUL   = 4'b1000,
        ST_PUL_W = 4'b1001,
        ST_RTI   = 4'b1010,
        ST_RTI_W = 4'b1011,
        ST_SPH   = 4'b1100,
        ST_SPL   = 4'b1101,
        ST_RUN   = 4'b1110
    } mse_state_t;

    typedef struct packed {
        logic    vld;
        mse_op_t op;
    } mse_cpu_req_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] addr;
        logic [7:0] mask;
    } mse_ram_wr_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } mse_byte_t;

    typedef struct packed {
        mse_state_t      state;
        logic            por;
        logic            unlock;
        logic            inval;
        logic            match;
        logic [2:0]      cnt;
        logic [7:0][7:0] shadow;
        logic [15:0]     sp_inc;
        mse_cpu_req_t    cpu;
        mse_ram_wr_t     ram;
        mse_byte_t       tx;
        logic            brk;
        logic            ill;
        logic [15:0]     pc_hi;
        logic [15:0]     pc_lo;
    } mse_regs_t;

endpackage : mse_pkg

//--- core/mse_monitor_entry.sv
`timescale 1ns/1ps

// What this block does
// - Monitor entry issues software interrupt, then pushes index high byte.
// - Command 0x28 pops index high byte, then returns from interrupt.
// - Read-stack-pointer command replies stack pointer plus one.
// - Stacked return address sits at SP+5 (high) and SP+6 (low).
// - After power-on, wait for exactly eight security bytes from host.
// - All eight equal stored bytes: unlock nonvolatile reads and execution.
// - Unlock survives every reset except power-on; no re-entry needed.
// - Mismatch: stay in monitor, nonvolatile reads return invalid value.
// - Locked nonvolatile instruction fetch raises illegal-address reset.
// - After power-on, break sent only after all eight security bytes arrived; warm reset sends it with no bytes.
// - Matching code sets bit 6 of RAM byte 0x80.
// - Mass erase sets all eight security bytes to 0xFF.
module mse_monitor_entry
    import mse_pkg::*;
#(
    parameter logic [7:0] RUN_CMD  = MSE_RUN_CMD,
    parameter logic [7:0] RDSP_CMD = MSE_RDSP_CMD
) (
    // Clock and resets
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst,
    input  wire logic            i_sys_rst,
    // Stored code and erase strobe
    input  wire logic [7:0][7:0] i_sec_bytes,
    input  wire logic            i_mass_erase,
    // Received and transmitted monitor bytes
    input  wire logic            i_rx_vld,
    input  wire logic [7:0]      i_rx_byte,
    input  wire logic            i_tx_ready,
    // Core operation handshake and stack pointer
    input  wire logic            i_cpu_done,
    input  wire logic [15:0]     i_sp,
    // Instruction fetch watch
    input  wire logic            i_fetch_vld,
    input  wire logic            i_fetch_nv,
    // Core operation requests
    output logic                 o_cpu_op_vld,
    output mse_op_t              o_cpu_op,
    // Security flag write into RAM
    output logic                 o_ram_wr,
    output logic [7:0]           o_ram_addr,
    output logic [7:0]           o_ram_mask,
    // Reply bytes and break request
    output logic                 o_tx_vld,
    output logic [7:0]           o_tx_byte,
    output logic                 o_break,
    // Security status
    output logic                 o_unlocked,
    output logic                 o_nv_rd_invalid,
    output logic                 o_illegal_rst,
    // Stacked return address slots
    output logic [15:0]          o_pc_hi_addr,
    output logic [15:0]          o_pc_lo_addr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mse_regs_t r_q;
    mse_regs_t r_d;

    // ------------------------------------------------------------
    // Reset image and helpers
    // ------------------------------------------------------------
    // Reset image; power-on leaves the part locked
    localparam mse_regs_t MSE_RST = '{
        state:  ST_SWI,
        por:    1'b1,
        unlock: 1'b0,
        inval:  1'b1,
        match:  1'b1,
        cnt:    3'h0,
        shadow: {MSE_SEC_BYTES{MSE_ERASED}},
        sp_inc: 16'h0000,
        cpu:    '{vld: 1'b0, op: software_interrupt_op},
        ram:    '{vld: 1'b0, addr: 8'h00, mask: 8'h00},
        tx:     '{vld: 1'b0, data: 8'h00},
        brk:    1'b0,
        ill:    1'b0,
        pc_hi:  16'h0000,
        pc_lo:  16'h0000
    };

    // Issue one core operation request
    function automatic mse_cpu_req_t cpu_req(input mse_op_t op);
        cpu_req = '{vld: 1'b1, op: op};
    endfunction : cpu_req

    // Stack slot address relative to the live stack pointer
    function automatic logic [15:0] stack_slot(input logic [15:0] sp, input logic [15:0] ofs);
        stack_slot = sp + ofs;
    endfunction : stack_slot

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        // Hold all state; pulses drop unless a state raises them
        r_d         = r_q;
        r_d.cpu.vld = 1'b0;
        r_d.ram.vld = 1'b0;
        r_d.brk     = 1'b0;

        // Locked fetch from nonvolatile space is illegal
        r_d.ill = i_fetch_vld && i_fetch_nv && !r_q.unlock;

        case (r_q.state)
            // ------------------------------------------------------------
            // Entry: software interrupt, then index high push
            // ------------------------------------------------------------
            ST_SWI: begin
                if (r_q.por) begin
                    r_d.shadow = i_sec_bytes;
                end
                r_d.cpu   = cpu_req(software_interrupt_op);
                r_d.state = ST_SWI_W;
            end
            // Wait for the core to take the interrupt
            ST_SWI_W: begin
                if (i_cpu_done) begin
                    r_d.state = ST_PSH;
                end
            end
            // Complete the stacked context with index high
            ST_PSH: begin
                r_d.cpu   = cpu_req(push_index_high_op);
                r_d.state = ST_PSH_W;
            end
            // Stack is final once the push is done
            ST_PSH_W: begin
                if (i_cpu_done) begin
                    // Return address slots on the entry stack
                    r_d.pc_hi = stack_slot(i_sp, MSE_PC_HI_OFS);
                    r_d.pc_lo = stack_slot(i_sp, MSE_PC_LO_OFS);
                    r_d.cnt   = 3'h0;
                    r_d.match = 1'b1;
                    // Only power-on demands the code
                    r_d.state = r_q.por ? ST_SEC : ST_BRK;
                end
            end
            // ------------------------------------------------------------
            // Collect and compare security bytes in order
            // ------------------------------------------------------------
            ST_SEC: begin
                if (i_rx_vld) begin
                    r_d.match = r_q.match && (i_rx_byte == r_q.shadow[r_q.cnt]);
                    r_d.cnt   = r_q.cnt + 3'h1;
                    // Last byte settles the lock state
                    if (r_q.cnt == 3'(MSE_SEC_BYTES - 1)) begin
                        r_d.unlock = r_d.match;
                        r_d.por    = 1'b0;
                        r_d.state  = ST_FLAG;
                    end
                end
            end
            // ------------------------------------------------------------
            // Record a good code in RAM for the host
            // ------------------------------------------------------------
            ST_FLAG: begin
                if (r_q.unlock) begin
                    r_d.ram.vld  = 1'b1;
                    r_d.ram.addr = MSE_FLAG_ADDR;
                    r_d.ram.mask = 8'(1 << MSE_FLAG_BIT);
                end
                r_d.state = ST_BRK;
            end
            // ------------------------------------------------------------
            // Ready for commands after the code phase, or at once after warm reset
            // ------------------------------------------------------------
            ST_BRK: begin
                r_d.brk   = 1'b1;
                r_d.state = ST_CMD;
            end
            // Command decode; unknown bytes are ignored
            ST_CMD: begin
                if (i_rx_vld && (i_rx_byte == RUN_CMD)) begin
                    // Stacked context may have been edited by host
                    r_d.state = ST_PUL;
                end else if (i_rx_vld && (i_rx_byte == RDSP_CMD)) begin
                    r_d.sp_inc  = stack_slot(i_sp, MSE_SP_INC);
                    r_d.tx.vld  = 1'b1;
                    r_d.tx.data = r_d.sp_inc[15:8];
                    r_d.state   = ST_SPH;
                end
            end
            // ------------------------------------------------------------
            // Resume: pop index high, return from interrupt
            // ------------------------------------------------------------
            ST_PUL: begin
                r_d.cpu   = cpu_req(pop_index_high_op);
                r_d.state = ST_PUL_W;
            end
            // Wait for the pop before returning
            ST_PUL_W: begin
                if (i_cpu_done) begin
                    r_d.state = ST_RTI;
                end
            end
            // Return to the stacked program counter
            ST_RTI: begin
                r_d.cpu   = cpu_req(return_from_interrupt_op);
                r_d.state = ST_RTI_W;
            end
            // Core leaves monitor once the return is done
            ST_RTI_W: begin
                if (i_cpu_done) begin
                    r_d.state = ST_RUN;
                end
            end
            // ------------------------------------------------------------
            // Stack pointer reply, high byte then low
            // ------------------------------------------------------------
            ST_SPH: begin
                if (i_tx_ready) begin
                    r_d.tx.data = r_q.sp_inc[7:0];
                    r_d.state   = ST_SPL;
                end
            end
            // Low byte accepted ends the reply
            ST_SPL: begin
                if (i_tx_ready) begin
                    r_d.tx.vld = 1'b0;
                    r_d.state  = ST_CMD;
                end
            end
            // User code runs; idle until the next reset
            ST_RUN: begin
                r_d.state = ST_RUN;
            end
            // Unused codes fall back to entry
            default: begin
                r_d.state = ST_SWI;
            end
        endcase

        // ------------------------------------------------------------
        // Erase wipes the code copy, wins over a load
        // ------------------------------------------------------------
        if (i_mass_erase) begin
            r_d.shadow = {MSE_SEC_BYTES{MSE_ERASED}};
        end

        // ------------------------------------------------------------
        // Warm reset restarts entry, keeps lock state and code copy
        // ------------------------------------------------------------
        if (i_sys_rst) begin
            r_d.state  = ST_SWI;
            r_d.por    = 1'b0;
            r_d.cpu    = MSE_RST.cpu;
            r_d.ram    = MSE_RST.ram;
            r_d.tx     = MSE_RST.tx;
            r_d.brk    = 1'b0;
            r_d.cnt    = 3'h0;
        end

        // Invalid-read flag follows the final lock state
        r_d.inval = !r_d.unlock;
    end

    // ------------------------------------------------------------
    // Registers; only power-on clears the lock
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            r_q <= MSE_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Core operation requests
    assign o_cpu_op_vld    = r_q.cpu.vld;
    assign o_cpu_op        = r_q.cpu.op;

    // Security flag write
    assign o_ram_wr        = r_q.ram.vld;
    assign o_ram_addr      = r_q.ram.addr;
    assign o_ram_mask      = r_q.ram.mask;

    // Reply byte and break request
    assign o_tx_vld        = r_q.tx.vld;
    assign o_tx_byte       = r_q.tx.data;
    assign o_break         = r_q.brk;

    // Security status, all registered
    assign o_unlocked      = r_q.unlock;
    assign o_nv_rd_invalid = r_q.inval;
    assign o_illegal_rst   = r_q.ill;

    // Stacked return address slots
    assign o_pc_hi_addr    = r_q.pc_hi;
    assign o_pc_lo_addr    = r_q.pc_lo;

endmodule : mse_monitor_entry

//--- test/mse_monitor_entry_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module mse_chk
    import mse_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_sys_rst,
    input wire logic        i_cpu_done,
    input wire logic [15:0] i_sp,
    input wire logic        i_fetch_vld,
    input wire logic        i_fetch_nv,
    input wire logic        o_cpu_op_vld,
    input wire mse_op_t     o_cpu_op,
    input wire logic        o_ram_wr,
    input wire logic [7:0]  o_ram_addr,
    input wire logic        o_tx_vld,
    input wire logic [7:0]  o_tx_byte,
    input wire logic        o_break,
    input wire logic        o_unlocked,
    input wire logic        o_nv_rd_invalid,
    input wire logic        o_illegal_rst,
    input wire logic [15:0] o_pc_hi_addr
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Flag write then break request
    sequence flag_then_break;
        o_ram_wr && o_ram_addr == MSE_FLAG_ADDR ##1 o_break;
    endsequence
    chk_entry_swi:
        assert property ($past(i_rst) |-> ##[0:2] (o_cpu_op_vld && o_cpu_op == software_interrupt_op))
        else $error("no entry interrupt");
    chk_op_after_done:
        assert property (o_cpu_op_vld && o_cpu_op inside {push_index_high_op, return_from_interrupt_op}
            |-> $past(i_cpu_done, 2)) else $error("op not after done");
    chk_pc_offset:
        assert property ($changed(o_pc_hi_addr) |-> o_pc_hi_addr == $past(i_sp) + 16'h0005)
        else $error("bad pc address");
    chk_reply_high:
        assert property ($rose(o_tx_vld) |-> o_tx_byte == 8'($past(i_sp + 16'h0001) >> 8))
        else $error("bad reply byte");
    chk_flag_break:
        assert property ($rose(o_unlocked) |=> flag_then_break) else $error("no flag or break");
    chk_unlock_kept:
        assert property (o_unlocked |=> o_unlocked) else $error("unlock lost");
    chk_nv_invalid:
        assert property (o_nv_rd_invalid == !o_unlocked) else $error("bad invalid flag");
    chk_illegal_fetch:
        assert property (i_fetch_vld && i_fetch_nv && !o_unlocked |=> o_illegal_rst || i_sys_rst)
        else $error("no illegal reset");
endmodule : mse_chk

bind mse_monitor_entry mse_chk u_chk (.*);

//--- test/mse_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host on the monitor line
// ----------------------------------------
module mse_host_model (
    input  wire logic       i_ref_clk,
    output logic            o_rx_vld,
    output logic [7:0]      o_rx_byte,
    output logic            o_tx_ready,
    input  wire logic       i_tx_vld,
    input  wire logic [7:0] i_tx_byte
);
    logic [7:0] rx_q[$];
    initial begin
        o_rx_vld = 0;
        o_rx_byte = 8'h00;
        o_tx_ready = 0;
    end
    // Reply acceptance with random stalls
    always @(negedge i_ref_clk) o_tx_ready <= 1'($urandom % 2);
    always @(posedge i_ref_clk) if (i_tx_vld && o_tx_ready) rx_q.push_back(i_tx_byte);
    // One byte, then the line shows the inverse
    task automatic send(input logic [7:0] b);
        @(negedge i_ref_clk);
        o_rx_vld = 1;
        o_rx_byte = b;
        @(negedge i_ref_clk);
        o_rx_vld = 0;
        o_rx_byte = ~b;
    endtask : send
endmodule : mse_host_model

//--- test/mse_monitor_entry_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module mse_monitor_entry_tb;
    import mse_pkg::*;
    logic i_ref_clk, i_rst = 1, i_sys_rst = 0, i_mass_erase = 0, i_cpu_done = 0, i_fetch_vld = 0, i_fetch_nv = 0;
    logic [7:0][7:0] i_sec_bytes = '0;
    logic [15:0] i_sp = '0;
    logic i_rx_vld, i_tx_ready, o_cpu_op_vld, o_ram_wr, o_tx_vld, o_break, o_unlocked, o_nv_rd_invalid, o_illegal_rst;
    logic [7:0] i_rx_byte, o_ram_addr, o_ram_mask, o_tx_byte;
    logic [15:0] o_pc_hi_addr, o_pc_lo_addr;
    mse_op_t o_cpu_op;
    mse_op_t ops_q[$];
    logic [7:0] code[8];
    int fails = 0, checks = 0, pend = 0, brk_n = 0, wr_n = 0, ill_n = 0, t;
    mse_monitor_entry DUT (.*);
    mse_host_model HOST (.i_ref_clk, .o_rx_vld(i_rx_vld), .o_rx_byte(i_rx_byte), .o_tx_ready(i_tx_ready),
        .i_tx_vld(o_tx_vld), .i_tx_byte(o_tx_byte));
    initial begin
        i_ref_clk = 0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // Core responder and event counters
    always @(posedge i_ref_clk) begin
        if (o_cpu_op_vld) ops_q.push_back(o_cpu_op);
        if (o_cpu_op_vld) pend = 1 + $urandom % 3;
        brk_n += o_break;
        wr_n += o_ram_wr;
        ill_n += o_illegal_rst;
    end
    always @(negedge i_ref_clk) begin
        i_cpu_done = (pend == 1);
        if (pend > 0) pend--;
    end
    task automatic finish_test();
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : cyc
    task automatic wait_ops(input int n);
        for (t = 0; ops_q.size() < n && t < 60; t++) cyc(1);
        cyc(8);
    endtask : wait_ops
    // Power-on entry: 0 match, 1 one bit wrong, 2 erase then blank code
    task automatic enter(input int mode);
        logic [7:0] b[8];
        cyc(1);
        i_rst = 1;
        foreach (code[k]) code[k] = 8'($urandom_range(0, 254));
        foreach (code[k]) i_sec_bytes[k] = code[k];
        cyc(10);
        i_rst = 0;
        ops_q.delete();
        brk_n = 0;
        wr_n = 0;
        ill_n = 0;
        cyc(1);
        i_mass_erase = (mode == 2);
        cyc(1);
        i_mass_erase = 0;
        if (mode == 2) foreach (code[k]) code[k] = 8'hFF;
        b = code;
        if (mode == 1) b[$urandom % 8] ^= 8'(1 << ($urandom % 8));
        wait_ops(2);
        `CHK("op0", software_interrupt_op, ops_q[0])
        `CHK("op1", push_index_high_op, ops_q[1])
        `CHK("pc hi", i_sp + 16'h0005, o_pc_hi_addr)
        `CHK("pc lo", i_sp + 16'h0006, o_pc_lo_addr)
        for (int k = 0; k < 7; k++) HOST.send(b[k]);
        cyc(4);
        `CHK("early break", 0, brk_n)
        HOST.send(b[7]);
        cyc(6);
        `CHK("unlocked", 1'(b == code), o_unlocked)
        `CHK("nv invalid", 1'(b != code), o_nv_rd_invalid)
        `CHK("flag", int'(b == code), wr_n)
        `CHK("addr", (b == code) ? 8'h80 : 8'h00, o_ram_addr)
        `CHK("mask", (b == code) ? 8'h40 : 8'h00, o_ram_mask)
        `CHK("break", 1, brk_n)
    endtask : enter
    task automatic fetch(input logic nv, input int exp);
        cyc(1);
        i_fetch_vld = 1;
        i_fetch_nv = nv;
        cyc(1);
        i_fetch_vld = 0;
        cyc(2);
        `CHK("illegal", exp, ill_n)
    endtask : fetch
    initial begin
        #(40ns * 20000);
        fails++;
        finish_test();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h32c0_73cc));
        i_sp = 16'($urandom);
        enter(0);
        HOST.rx_q.delete();
        HOST.send(MSE_RDSP_CMD);
        for (t = 0; HOST.rx_q.size() < 2 && t < 60; t++) cyc(1);
        `CHK("sp hi", 8'((i_sp + 16'h0001) >> 8), HOST.rx_q[0])
        `CHK("sp lo", 8'(i_sp + 16'h0001), HOST.rx_q[1])
        fetch(1, 0);
        i_sys_rst = 1;
        ops_q.delete();
        brk_n = 0;
        cyc(1);
        i_sys_rst = 0;
        wait_ops(2);
        `CHK("warm unlock", 1'b1, o_unlocked)
        `CHK("warm break", 1, brk_n)
        HOST.send(MSE_RUN_CMD);
        wait_ops(4);
        `CHK("op2", pop_index_high_op, ops_q[2])
        `CHK("op3", return_from_interrupt_op, ops_q[3])
        enter(1);
        `CHK("invalid", 1'b1, o_nv_rd_invalid)
        fetch(0, 0);
        fetch(1, 1);
        enter(2);
        finish_test();
    end
endmodule : mse_monitor_entry_tb
